/* File: verilog/atb_bridge.sv */
// Task file PIO bridge with DMA interrupt reason register
// How it works
// RQ1 - Address 48h drives selects high/low, address 001 (error/feature).
// RQ2 - Address 49h drives selects high/low, address 010 (sector count).
// RQ3 - Address 4Ah drives selects high/low, address 011 (sector number).
// RQ4 - Address 4Bh drives selects high/low, address 100 (cylinder low).
// RQ5 - Address 4Ch drives selects high/low, address 101 (cylinder high).
// RQ6 - Address 4Dh drives selects high/low, address 110 (drive/head).
// RQ7 - Address 44h drives selects high/low, address 111 (command).
// RQ8 - Command register is write-only; reads never reach the drive.
// RQ9 - Reading the command register returns FFh.
// RQ10 - Address 4Eh drives selects low/high, address 110 (alternate status).
// RQ11 - Address 4Fh drives selects low/high, address 111 (drive address).
// RQ12 - 16-bit interrupt reason register at 50h shows DMA interrupt sources.
// RQ13 - Every reason bit is refreshed when a DMA command completes.
// RQ14 - Writing one clears a reason bit other than read-only bit 15; writing zero leaves it.
// RQ15 - Host reads reason and ANDs with enable to find the source.
// RQ16 - Software writes the command register last, others any order.
// RQ17 - Sources interrupt only when enabled; enables zero after reset.
// RQ18 - Each task file access with byte lane 0 selected, except a command read, makes exactly one PIO cycle of that direction.
`timescale 1ns/1ps
module atb_bridge
  import atb_pkg::*;
#(
  parameter int STROBE_CYC = ATB_STROBE_CYC,
  parameter int SETUP_CYC  = ATB_SETUP_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             drive_select_high_bank_n,
  output logic             drive_select_cmd_bank_n,
  output logic             drive_reg_addr_bit2,
  output logic             drive_reg_addr_bit1_shared,
  output logic             drive_reg_addr_bit0_shared,
  output logic             drive_read_n,
  output logic             drive_write_n,
  input  wire logic [7:0]  drive_data_i,
  output logic      [7:0]  drive_data_o,
  output logic             drive_data_oe,
  input  wire logic        dma_cmd_done,
  input  wire logic [15:0] dma_reason_sources,
  output logic             dma_irq
);

  atb_state_t     state_q;
  atb_drive_sel_t sel_d;
  atb_drive_sel_t sel_q;
  logic           tf_hit;
  logic           req;
  logic           req_tf;
  logic [7:0]     cnt_q;
  logic           wr_q;
  logic [15:0]    reason_q;
  logic [15:0]    enable_q;
  logic [15:0]    clr_mask;
  logic [15:0]    wdat16;

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && state_q == ATB_IDLE;
  assign wdat16 = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

  // Task file address decode
  always_comb begin
    tf_hit = 1'b1;
    sel_d  = '{high_bank_n: 1'b1, cmd_bank_n: 1'b0, addr: 3'b000};
    case (wb_adr_i)
      // RQ1 error feature pattern
      ATB_OFS_ERR_FEAT:   sel_d.addr = 3'b001;
      // RQ2 sector count pattern
      ATB_OFS_SECT_CNT:   sel_d.addr = 3'b010;
      // RQ3 sector number pattern
      ATB_OFS_SECT_NUM:   sel_d.addr = 3'b011;
      // RQ4 cylinder low pattern
      ATB_OFS_CYL_LOW:    sel_d.addr = 3'b100;
      // RQ5 cylinder high pattern
      ATB_OFS_CYL_HIGH:   sel_d.addr = 3'b101;
      // RQ6 drive head pattern
      ATB_OFS_DRIVE_HEAD: sel_d.addr = 3'b110;
      // RQ7 command pattern
      ATB_OFS_COMMAND:    sel_d.addr = 3'b111;
      // RQ10 alternate status pattern
      ATB_OFS_ALT_STAT: begin
        sel_d = '{high_bank_n: 1'b0, cmd_bank_n: 1'b1, addr: 3'b110};
      end
      // RQ11 drive address pattern
      ATB_OFS_DRIVE_ADDR: begin
        sel_d = '{high_bank_n: 1'b0, cmd_bank_n: 1'b1, addr: 3'b111};
      end
      default: tf_hit = 1'b0;
    endcase
  end

  // RQ8 command reads stay local
  assign req_tf = req && tf_hit && wb_sel_i[0] && !(wb_adr_i == ATB_OFS_COMMAND && !wb_we_i);

  // PIO cycle sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q  <= ATB_IDLE;
      cnt_q    <= 8'h00;
      wr_q     <= 1'b0;
      sel_q    <= '{high_bank_n: 1'b1, cmd_bank_n: 1'b1, addr: 3'b000};
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      drive_read_n  <= 1'b1;
      drive_write_n <= 1'b1;
      drive_data_o  <= 8'h00;
      drive_data_oe <= 1'b0;
    end else begin
      wb_ack_o <= 1'b0;
      case (state_q)
        ATB_IDLE: begin
          // RQ18 one PIO cycle per access
          if (req_tf) begin
            sel_q         <= sel_d;
            wr_q          <= wb_we_i;
            drive_data_o  <= wb_dat_i[7:0];
            drive_data_oe <= wb_we_i;
            cnt_q         <= 8'(SETUP_CYC);
            state_q       <= ATB_SETUP;
          end else if (req) begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
              // RQ9 command read answer
              ATB_OFS_COMMAND:    wb_dat_o <= {24'h000000, ATB_CMD_READ_VALUE};
              // RQ12 reason readback
              ATB_OFS_IRQ_REASON: wb_dat_o <= {16'h0000, reason_q};
              ATB_OFS_IRQ_ENABLE: wb_dat_o <= {16'h0000, enable_q};
              ATB_OFS_PIO_STATUS: wb_dat_o <= 32'h0000_0000;
              default:            wb_dat_o <= 32'h0000_0000;
            endcase
          end
        end
        ATB_SETUP: begin
          if (cnt_q <= 8'h01) begin
            cnt_q         <= 8'(STROBE_CYC);
            drive_read_n  <= wr_q;
            drive_write_n <= !wr_q;
            state_q       <= ATB_STROBE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ATB_STROBE: begin
          if (cnt_q <= 8'h01) begin
            drive_read_n  <= 1'b1;
            drive_write_n <= 1'b1;
            wb_dat_o      <= {24'h000000, drive_data_i};
            state_q       <= ATB_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ATB_HOLD: begin
          drive_data_oe <= 1'b0;
          sel_q         <= '{high_bank_n: 1'b1, cmd_bank_n: 1'b1, addr: 3'b000};
          wb_ack_o      <= 1'b1;
          state_q       <= ATB_ACK;
        end
        ATB_ACK: state_q <= ATB_IDLE;
        default: state_q <= ATB_IDLE;
      endcase
    end
  end

  assign drive_select_high_bank_n   = sel_q.high_bank_n;
  assign drive_select_cmd_bank_n    = sel_q.cmd_bank_n;
  assign drive_reg_addr_bit2        = sel_q.addr[2];
  assign drive_reg_addr_bit1_shared = sel_q.addr[1];
  assign drive_reg_addr_bit0_shared = sel_q.addr[0];

  // RQ14 write one to clear
  assign clr_mask = (req && wb_we_i && wb_adr_i == ATB_OFS_IRQ_REASON) ? (wdat16 & ATB_REASON_W1C) : 16'h0000;

  // Reason register, refresh wins over clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reason_q <= ATB_REASON_RESET;
    end else if (dma_cmd_done) begin
      // RQ13 refresh on completion
      reason_q <= dma_reason_sources & ATB_REASON_MASK;
    end else begin
      reason_q <= reason_q & ~clr_mask;
    end
  end

  // RQ17 enable register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      enable_q <= ATB_ENABLE_RESET;
    end else if (req && wb_we_i && wb_adr_i == ATB_OFS_IRQ_ENABLE) begin
      enable_q <= wdat16 & ATB_REASON_W1C;
    end
  end

  // RQ17 gated interrupt
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dma_irq <= 1'b0;
    end else begin
      dma_irq <= |(reason_q & enable_q);
    end
  end

endmodule

/* File: verilog/atb_pkg.sv */
// Package of constants and types for the task file PIO bridge
package atb_pkg;
  // Register byte offsets
  localparam logic [7:0] ATB_OFS_COMMAND    = 8'h44;
  localparam logic [7:0] ATB_OFS_ERR_FEAT   = 8'h48;
  localparam logic [7:0] ATB_OFS_SECT_CNT   = 8'h49;
  localparam logic [7:0] ATB_OFS_SECT_NUM   = 8'h4a;
  localparam logic [7:0] ATB_OFS_CYL_LOW    = 8'h4b;
  localparam logic [7:0] ATB_OFS_CYL_HIGH   = 8'h4c;
  localparam logic [7:0] ATB_OFS_DRIVE_HEAD = 8'h4d;
  localparam logic [7:0] ATB_OFS_ALT_STAT   = 8'h4e;
  localparam logic [7:0] ATB_OFS_DRIVE_ADDR = 8'h4f;
  localparam logic [7:0] ATB_OFS_IRQ_REASON = 8'h50;
  localparam logic [7:0] ATB_OFS_IRQ_ENABLE = 8'h54;
  localparam logic [7:0] ATB_OFS_PIO_STATUS = 8'h58;
  // Read answer of the write-only command register
  localparam logic [7:0] ATB_CMD_READ_VALUE = 8'hff;
  // Reason bits that exist (15 read-only, 12..8, 4..1 clearable)
  localparam logic [15:0] ATB_REASON_MASK   = 16'h9f1e;
  localparam logic [15:0] ATB_REASON_W1C    = 16'h1f1e;
  localparam logic [15:0] ATB_REASON_RESET  = 16'h0000;
  localparam logic [15:0] ATB_ENABLE_RESET  = 16'h0000;
  localparam int          ATB_PIO_STATUS_BUSY = 0;
  // PIO strobe timing
  localparam int ATB_CLK_MHZ        = 25;
  localparam int ATB_STROBE_NS      = 165;
  localparam int ATB_SETUP_NS       = 70;
  localparam int ATB_STROBE_CYC     = (ATB_STROBE_NS * ATB_CLK_MHZ + 999) / 1000;
  localparam int ATB_SETUP_CYC      = (ATB_SETUP_NS * ATB_CLK_MHZ + 999) / 1000;

  // Drive select and address pattern
  typedef struct packed {
    logic       high_bank_n;
    logic       cmd_bank_n;
    logic [2:0] addr;
  } atb_drive_sel_t;

  typedef enum logic [2:0] {
    ATB_IDLE,
    ATB_SETUP,
    ATB_STROBE,
    ATB_HOLD,
    ATB_ACK
  } atb_state_t;
endpackage

/* File: verif/atb_drive_model.sv */
// Behavioural drive on the IDE side
`timescale 1ns/1ps
module atb_drive_model (
  input  wire logic       clk_sys,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [4:0] pat,
  input  wire logic [7:0] dout,
  output logic      [7:0] din,
  output int              n_rd,
  output int              n_wr,
  output logic      [4:0] last_pat,
  output logic      [7:0] last_wr
);
  logic rd_q = 1'b1;
  logic wr_q = 1'b1;
  initial begin
    n_rd = 0;
    n_wr = 0;
    din = 8'h00;
  end
  // Counts strobes, records pattern, answers reads
  always @(posedge clk_sys) begin
    rd_q <= rd_n;
    wr_q <= wr_n;
    if (!rd_n && rd_q) begin
      n_rd <= n_rd + 1;
      last_pat <= pat;
    end
    if (!wr_n && wr_q) begin
      n_wr <= n_wr + 1;
      last_pat <= pat;
    end
    if (!wr_n) last_wr <= dout;
    din <= rd_n ? ~din : {3'h5, pat};
  end
endmodule

/* File: verif/atb_bridge_checker.sv */
// Port checker of the task file bridge
`timescale 1ns/1ps
module atb_bridge_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [4:0]  pat,
  input wire logic        drive_read_n,
  input wire logic        drive_write_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [4:0] exp_pat;
  always_comb begin
    case (wb_adr_i)
      8'h44: exp_pat = 5'h17;
      8'h48: exp_pat = 5'h11;
      8'h49: exp_pat = 5'h12;
      8'h4a: exp_pat = 5'h13;
      8'h4b: exp_pat = 5'h14;
      8'h4c: exp_pat = 5'h15;
      8'h4d: exp_pat = 5'h16;
      8'h4e: exp_pat = 5'h0e;
      8'h4f: exp_pat = 5'h0f;
      default: exp_pat = 5'h1f;
    endcase
  end
  chk_pio_pattern: assert property ((!drive_read_n || !drive_write_n) |-> pat == exp_pat)
    else $error("drive pattern wrong");
  chk_cmd_noread: assert property (wb_cyc_i && !wb_we_i && wb_adr_i == 8'h44 |-> drive_read_n)
    else $error("command read reached drive");
  chk_cmd_read_ff: assert property (wb_ack_o && wb_cyc_i && !wb_we_i && wb_adr_i == 8'h44 |-> wb_dat_o[7:0] == 8'hff)
    else $error("command read not ff");
  chk_reason_bits: assert property (wb_ack_o && wb_cyc_i && !wb_we_i && wb_adr_i == 8'h50 |-> (wb_dat_o & 32'hffff60e1) == 0)
    else $error("reserved reason bits set");
  chk_write_len: assert property ($fell(drive_write_n) |-> !drive_write_n [*5] ##1 drive_write_n)
    else $error("write strobe length");
  chk_read_len: assert property ($fell(drive_read_n) |-> !drive_read_n [*5] ##1 drive_read_n)
    else $error("read strobe length");
  chk_ack_after: assert property ($rose(drive_write_n) || $rose(drive_read_n) |=> wb_ack_o)
    else $error("no ack after strobe");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_one_dir: assert property (!drive_write_n |-> drive_read_n)
    else $error("both strobes low");
endmodule
bind atb_bridge atb_bridge_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .drive_read_n(drive_read_n),
  .pat({drive_select_high_bank_n, drive_select_cmd_bank_n, drive_reg_addr_bit2, drive_reg_addr_bit1_shared,
    drive_reg_addr_bit0_shared}), .drive_write_n(drive_write_n));

/* File: verif/tb_top.sv */
// Testbench of the task file bridge
`timescale 1ns/1ps
module tb_top;
  import atb_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic        done = 1'b0;
  logic [15:0] src = 16'h0;
  logic [31:0] dat_o, q;
  logic        ack, hb_n, cb_n, a2, a1, a0, rd_n, wr_n, oe, irq;
  logic [7:0]  din, dout, last_wr;
  logic [4:0]  last_pat;
  int          n_rd, n_wr, r, w;
  int          failures = 0;
  int          n_tests = 0;
  logic [7:0]  adrs [9] = '{8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h44};
  logic [4:0]  pats [9] = '{5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h0e, 5'h0f, 5'h17};
  always #20 clk_sys = ~clk_sys;
  atb_bridge u_atb_bridge (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .drive_select_high_bank_n(hb_n), .drive_select_cmd_bank_n(cb_n), .drive_reg_addr_bit2(a2),
    .drive_reg_addr_bit1_shared(a1), .drive_reg_addr_bit0_shared(a0), .drive_read_n(rd_n), .drive_write_n(wr_n),
    .drive_data_i(din), .drive_data_o(dout), .drive_data_oe(oe), .dma_cmd_done(done),
    .dma_reason_sources(src), .dma_irq(irq));
  atb_drive_model u_atb_drive_model (.clk_sys(clk_sys), .rd_n(rd_n), .wr_n(wr_n), .pat({hb_n, cb_n, a2, a1, a0}),
    .dout(dout), .din(din), .n_rd(n_rd), .n_wr(n_wr), .last_pat(last_pat), .last_wr(last_wr));
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) failures++;
    q = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic t_map;
    for (int i = 0; i < 9; i++) begin
      r = n_rd;
      w = n_wr;
      wb(1'b1, adrs[i], 32'h30 + i);
      check("pattern", pats[i], last_pat);
      check("wdata", 32'h30 + i, last_wr);
      check("wcount", w + 1, n_wr);
      check("oe idle", 1'b0, oe);
      check("selects idle", 2'b11, {hb_n, cb_n});
      wb(1'b0, adrs[i], 32'h0);
      check("rdata", i < 8 ? {3'h5, pats[i]} : ATB_CMD_READ_VALUE, q[7:0]);
      check("rcount", i < 8 ? r + 1 : r, n_rd);
    end
    $display("test map done");
  endtask
  task automatic t_reason;
    wb(1'b0, 8'h54, 32'h0);
    check("enable reset", ATB_ENABLE_RESET, q[15:0]);
    @(posedge clk_sys);
    src <= 16'hffff;
    done <= 1'b1;
    @(posedge clk_sys);
    done <= 1'b0;
    wb(1'b0, 8'h50, 32'h0);
    check("refresh", ATB_REASON_MASK, q[15:0]);
    check("irq off", 1'b0, irq);
    wb(1'b1, 8'h50, 32'h8102);
    wb(1'b1, 8'h50, 32'h0);
    wb(1'b0, 8'h50, 32'h0);
    check("w1c", 16'h9e1c, q[15:0]);
    wb(1'b1, 8'h54, 32'h4);
    repeat (3) @(posedge clk_sys);
    check("irq on", 1'b1, irq);
    wb(1'b0, 8'h50, 32'h0);
    check("source", 16'h4, q[15:0] & 16'h4);
    wb(1'b1, 8'h50, 32'h4);
    repeat (3) @(posedge clk_sys);
    check("irq clr", 1'b0, irq);
    src <= 16'h0;
    done <= 1'b1;
    @(posedge clk_sys);
    done <= 1'b0;
    wb(1'b0, 8'h50, 32'h0);
    check("refresh 0", 16'h0, q[15:0]);
    wb(1'b1, 8'h60, 32'hff);
    wb(1'b0, 8'h60, 32'h0);
    check("unmapped", 32'h0, q);
    $display("test reason done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_map;
    t_reason;
    report_and_stop;
  end
  initial begin
    #400000;
    failures++;
    report_and_stop;
  end
endmodule
